// ### core/windowed_watchdog_timer.sv
// Summary of operation
// - while enabled, missing restart before the time-out requests system reset
// - watchdog runs while period field is non-zero, idle when zero
// - eleven period codes select about 8 ms up to 8 s
// - normal mode: accepted restart starts a fresh period from zero
// - windowed mode while closed-window field non-zero, otherwise normal
// - windowed mode: restart during closed period requests system reset
// - open period follows closed period; restart needed within open period
// - on window enable or debug exit, closed window starts after first restart
// - counts ticks of the 1.024 kHz watchdog tick clock
// - control loads from fuse; non-zero fuse period starts enabled and locked
// - lock blocks control changes; software sets lock, clears only in debug
// - control and lock writes need the timed unlock procedure
// - keeps counting while enabled and its tick clock runs, except during debug halt
// - debug halt stops operation and clears the counter
// - leaving debug in windowed mode runs one normal time-out first
// - period and window writes cross over, sync pending flag high meanwhile
// - restart takes effect after two to three watchdog ticks
// - protected write accepted only within four accesses after the key
// - window sets open duration by period, closed by window field
// - sync pending flag needs no unlock
`timescale 1ns/1ps
`include "wdt_defs.svh"

module windowed_watchdog_timer
(
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // processor side
   input  wire logic        watchdog_restart_instruction,
   input  wire logic        debug_halt,
   input  wire logic [7:0]  watchdog_fuse_config,
   // watchdog tick clock pin
   input  wire logic        watchdog_tick_clock,
   // reset request
   output logic             sys_reset_req
);

   wdt_pkg::wd_cfg_s   watchdog_control_register;
   wdt_pkg::wd_cfg_s   act_cfg;
   wdt_pkg::wd_state_e state;
   logic        lock;
   logic        sync_pending_flag;
   logic [1:0]  sync_wait;
   logic        rst_pend;
   logic [1:0]  rst_wait;
   logic [2:0]  change_guard_unlock;
   logic        boot_done;
   logic        tick_meta;
   logic        tick_sync;
   logic        tick_prev;
   logic        debug_prev;
   logic [13:0] cnt;

   logic        tick;
   logic        bus_req;
   logic        wr_ok;
   logic        prot_ok;
   logic        ctrl_wr;
   logic        lock_wr;
   logic        restart_eff;
   logic        apply_cfg;
   logic [13:0] open_dur;
   logic [13:0] closed_dur;
   logic [13:0] cnt_inc;

   function automatic logic [13:0] dur(input logic [3:0] code);
      if (code == 4'h0)
         dur = 14'h0000;
      else if (code > `WDT_CODE_MAX)
         dur = `WDT_DUR_MAX;
      else
         dur = `WDT_DUR_BASE << (code - 4'h1);
   endfunction : dur

   assign bus_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ok       = bus_req & wb_we_i & wb_sel_i[0];
   assign prot_ok     = change_guard_unlock != 3'h0;
   assign ctrl_wr     = wr_ok & prot_ok & ~lock
                        & (wb_adr_i == `WDT_CTRL_ADDR);
   assign lock_wr     = wr_ok & prot_ok
                        & (wb_adr_i == `WDT_STATUS_ADDR);
   assign tick        = tick_sync & ~tick_prev;
   assign restart_eff = tick & rst_pend
                        & (rst_wait == `WDT_RESTART_TICKS - 2'h1);
   assign apply_cfg   = tick & sync_pending_flag
                        & (sync_wait == `WDT_SYNC_TICKS - 2'h1);
   assign open_dur    = dur(act_cfg.period);
   assign closed_dur  = dur(act_cfg.window);
   assign cnt_inc     = cnt + 14'h0001;

   // tick pin synchroniser and edge detect
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         tick_meta <= 1'b0;
         tick_sync <= 1'b0;
         tick_prev <= 1'b0;
      end
      else
      begin
         tick_meta <= watchdog_tick_clock;
         tick_sync <= tick_meta;
         tick_prev <= tick_sync;
      end
   end

   // wishbone answer, one cycle after request
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_req & ~wb_we_i)
         begin
            case (wb_adr_i)
               `WDT_CTRL_ADDR:
                  wb_dat_o[7:0] <= watchdog_control_register;
               `WDT_STATUS_ADDR:
               begin
                  wb_dat_o[`WDT_LOCK_BIT] <= lock;
                  wb_dat_o[`WDT_SYNC_BIT] <= sync_pending_flag;
                  wb_dat_o[9:8]           <= state;
               end
               default:
                  wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // unlock window counted in bus accesses
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         change_guard_unlock <= 3'h0;
      else if (wr_ok & (wb_adr_i == `WDT_KEY_ADDR)
               & (wb_dat_i[7:0] == `WDT_UNLOCK_KEY))
         change_guard_unlock <= `WDT_UNLOCK_SPAN;
      else if (ctrl_wr | lock_wr)
         change_guard_unlock <= 3'h0;
      else if (bus_req & prot_ok)
         change_guard_unlock <= change_guard_unlock - 3'h1;
   end

   // control register, fuse load and lock
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         watchdog_control_register <= `WDT_CTRL_RESET;
         lock      <= 1'b0;
         boot_done <= 1'b0;
      end
      else if (!boot_done)
      begin
         boot_done <= 1'b1;
         watchdog_control_register <= watchdog_fuse_config;
         lock <= watchdog_fuse_config[3:0] != 4'h0;
      end
      else
      begin
         if (ctrl_wr)
            watchdog_control_register <= wb_dat_i[7:0];
         if (lock_wr & wb_dat_i[`WDT_LOCK_BIT])
            lock <= 1'b1;
         else if (lock_wr & debug_halt)
            lock <= 1'b0;
      end
   end

   // transfer of control into the tick domain
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         sync_pending_flag <= 1'b0;
         sync_wait         <= 2'h0;
         act_cfg           <= `WDT_CTRL_RESET;
      end
      else if (ctrl_wr | !boot_done)
      begin
         sync_pending_flag <= 1'b1;
         sync_wait         <= 2'h0;
      end
      else if (apply_cfg)
      begin
         sync_pending_flag <= 1'b0;
         act_cfg           <= watchdog_control_register;
      end
      else if (tick & sync_pending_flag)
         sync_wait <= sync_wait + 2'h1;
   end

   // restart request crossing, new request wins over consumption
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         rst_pend <= 1'b0;
         rst_wait <= 2'h0;
      end
      else if (watchdog_restart_instruction)
      begin
         rst_pend <= 1'b1;
         rst_wait <= 2'h0;
      end
      else if (restart_eff)
         rst_pend <= 1'b0;
      else if (tick & rst_pend)
         rst_wait <= rst_wait + 2'h1;
   end

   // timing state machine, advances on each tick
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         state         <= wdt_pkg::WD_IDLE;
         cnt           <= 14'h0000;
         debug_prev    <= 1'b0;
         sys_reset_req <= 1'b0;
      end
      else if (tick)
      begin
         debug_prev <= debug_halt;
         if (debug_halt)
         begin
            cnt <= 14'h0000;
            if (act_cfg.period != 4'h0)
               state <= wdt_pkg::WD_NORMAL;
         end
         else if (act_cfg.period == 4'h0)
         begin
            state <= wdt_pkg::WD_IDLE;
            cnt   <= 14'h0000;
         end
         else if (apply_cfg & (act_cfg.window == 4'h0)
                  & (watchdog_control_register.window != 4'h0))
         begin
            state <= wdt_pkg::WD_NORMAL;
            cnt   <= 14'h0000;
         end
         else if (restart_eff)
         begin
            if (state == wdt_pkg::WD_CLOSED)
               sys_reset_req <= 1'b1;
            cnt <= 14'h0000;
            if (act_cfg.window != 4'h0)
               state <= wdt_pkg::WD_CLOSED;
            else
               state <= wdt_pkg::WD_NORMAL;
         end
         else
         begin
            case (state)
               wdt_pkg::WD_IDLE:
               begin
                  state <= wdt_pkg::WD_NORMAL;
                  cnt   <= 14'h0000;
               end
               wdt_pkg::WD_CLOSED:
               begin
                  cnt <= cnt_inc;
                  if (cnt_inc >= closed_dur)
                  begin
                     state <= wdt_pkg::WD_OPEN;
                     cnt   <= 14'h0000;
                  end
               end
               default:
               begin
                  cnt <= cnt_inc;
                  if (cnt_inc >= open_dur)
                     sys_reset_req <= 1'b1;
               end
            endcase
         end
      end
   end

   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_ack_once;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   property p_ack;
      @(posedge sys_clk) disable iff (rst) s_bus_req |=> s_ack_once;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not one cycle");

   property p_locked;
      @(posedge sys_clk) disable iff (rst)
         boot_done && lock |=> $stable(watchdog_control_register);
   endproperty
   a_locked: assert property (p_locked) else $error("locked ctrl changed");

   property p_no_key;
      @(posedge sys_clk) disable iff (rst)
         boot_done && change_guard_unlock == 3'h0
            |=> $stable(watchdog_control_register);
   endproperty
   a_no_key: assert property (p_no_key) else $error("ctrl without key");

   property p_lock_sticky;
      @(posedge sys_clk) disable iff (rst)
         boot_done && lock && !debug_halt |=> lock;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("lock fell");

   property p_sync_busy;
      @(posedge sys_clk) disable iff (rst)
         ctrl_wr |=> sync_pending_flag && $stable(act_cfg);
   endproperty
   a_sync_busy: assert property (p_sync_busy) else $error("no busy flag");

   property p_debug_clear;
      @(posedge sys_clk) disable iff (rst)
         tick && debug_halt |=> cnt == 14'h0000;
   endproperty
   a_debug_clear: assert property (p_debug_clear) else $error("cnt kept");

   property p_closed_hit;
      @(posedge sys_clk) disable iff (rst)
         tick && restart_eff && !debug_halt && act_cfg.period != 4'h0
         && !apply_cfg && state == wdt_pkg::WD_CLOSED |=> sys_reset_req;
   endproperty
   a_closed_hit: assert property (p_closed_hit) else $error("early restart");

   property p_timeout;
      @(posedge sys_clk) disable iff (rst)
         tick && !restart_eff && !debug_halt && !apply_cfg
         && act_cfg.period != 4'h0 && state == wdt_pkg::WD_OPEN
         && cnt_inc >= open_dur |=> sys_reset_req;
   endproperty
   a_timeout: assert property (p_timeout) else $error("no timeout reset");

   property p_disabled;
      @(posedge sys_clk) disable iff (rst)
         tick && !debug_halt && act_cfg.period == 4'h0
            |=> state == wdt_pkg::WD_IDLE && !$rose(sys_reset_req);
   endproperty
   a_disabled: assert property (p_disabled) else $error("ran while off");

   property p_restart_clear;
      @(posedge sys_clk) disable iff (rst)
         restart_eff && !debug_halt && act_cfg.period != 4'h0
            |=> cnt == 14'h0000;
   endproperty
   a_restart_clear: assert property (p_restart_clear) else $error("no clear");

endmodule : windowed_watchdog_timer

// ### shared/wdt_defs.svh
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// register byte addresses (index times four)
`define WDT_CTRL_IDX       8'h00
`define WDT_STATUS_IDX     8'h01
`define WDT_KEY_IDX        8'h02
`define WDT_CTRL_ADDR      8'h00
`define WDT_STATUS_ADDR    8'h04
`define WDT_KEY_ADDR       8'h08

// field positions
`define WDT_PERIOD_LSB     0
`define WDT_WINDOW_LSB     4
`define WDT_SYNC_BIT       0
`define WDT_LOCK_BIT       7

// reset values
`define WDT_CTRL_RESET     8'h00
`define WDT_STATUS_RESET   8'h00

// unlock key, arbitrary value
`define WDT_UNLOCK_KEY     8'ha5
// accesses after the key within which the protected write must come
`define WDT_UNLOCK_SPAN    3'h4

// watchdog clock: 1.024 kHz, codes 1..11 give 8..8192 ticks
`define WDT_TICK_HZ        1024
`define WDT_CODE_MAX       4'hb
`define WDT_DUR_BASE       14'h0008
`define WDT_DUR_MAX        14'h2000
// ticks needed to carry a write or a restart across
`define WDT_SYNC_TICKS     2'h2
`define WDT_RESTART_TICKS  2'h3

`endif

// ### shared/wdt_pkg.sv
package wdt_pkg;

   typedef enum logic [1:0]
   {
      WD_IDLE   = 2'b00,
      WD_NORMAL = 2'b01,
      WD_CLOSED = 2'b10,
      WD_OPEN   = 2'b11
   } wd_state_e;

   typedef struct packed
   {
      logic [3:0] window;
      logic [3:0] period;
   } wd_cfg_s;

endpackage : wdt_pkg

// ### bench/cpu_model.sv
`timescale 1ns/1ps

module cpu_model
(
   // clock
   input  wire logic sys_clk,
   // command from bench
   input  wire logic restart_cmd,
   // toward the watchdog
   output logic      watchdog_restart_instruction,
   output logic      watchdog_tick_clock
);
   logic pulse;

   initial watchdog_tick_clock = 1'h0;
   // scaled free running oscillator, phase unrelated to sys_clk
   always #103 watchdog_tick_clock = ~watchdog_tick_clock;

   // restart pulse is the command registered, one cycle later
   always_ff @(posedge sys_clk)
      pulse <= restart_cmd;
   assign watchdog_restart_instruction = pulse;
endmodule : cpu_model

// ### bench/testbench.sv
`timescale 1ns/1ps
`include "wdt_defs.svh"

module testbench;
   logic        sys_clk = 1'h0;
   logic        rst = 1'h1;
   logic        wb_cyc_i = 1'h0;
   logic        wb_stb_i = 1'h0;
   logic        wb_we_i = 1'h0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        watchdog_restart_instruction;
   logic        debug_halt = 1'h0;
   logic [7:0]  watchdog_fuse_config = 8'h25;
   logic        watchdog_tick_clock;
   logic        sys_reset_req;
   logic        restart_cmd = 1'h0;
   int          errors = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          seed = 32'heb91;
   logic [31:0] rd;
   logic [3:0]  code;

   always #10 sys_clk = ~sys_clk;

   windowed_watchdog_timer windowed_watchdog_timer_inst
   (
      .sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .debug_halt(debug_halt),
      .watchdog_restart_instruction(watchdog_restart_instruction),
      .watchdog_fuse_config(watchdog_fuse_config),
      .watchdog_tick_clock(watchdog_tick_clock),
      .sys_reset_req(sys_reset_req)
   );

   cpu_model cpu_model_inst
   (
      .sys_clk(sys_clk), .restart_cmd(restart_cmd),
      .watchdog_restart_instruction(watchdog_restart_instruction),
      .watchdog_tick_clock(watchdog_tick_clock)
   );

   task end_of_test;
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test

   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         errors = errors + 1;
         end_of_test();
      end
   end

   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t value %h exp %h", $time, got, exp);
      end
   endtask : check

   task check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t reset req %b exp %b", $time, got, exp);
      end
   endtask : check_bit

   // classic single cycle, held until ack
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic [3:0] s);
      @(posedge sys_clk);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, d};
      @(posedge sys_clk);
      while (wb_ack_o !== 1'h1)
         @(posedge sys_clk);
      rd = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask : bus

   task wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'h1, a, d, 4'hf);
   endtask : wr

   task rdr(input logic [7:0] a);
      bus(1'h0, a, 8'h00, 4'hf);
   endtask : rdr

   task ticks(input int n);
      repeat (n) @(posedge watchdog_tick_clock);
      @(posedge sys_clk);
   endtask : ticks

   task kick;
      @(posedge sys_clk);
      restart_cmd <= 1'h1;
      @(posedge sys_clk);
      restart_cmd <= 1'h0;
   endtask : kick

   // no control write while the crossing is pending
   task settle;
      rdr(`WDT_STATUS_ADDR);
      while (rd[0] !== 1'h0)
         rdr(`WDT_STATUS_ADDR);
   endtask : settle

   task boot(input logic [7:0] f);
      @(posedge sys_clk);
      rst <= 1'h1;
      debug_halt <= 1'h0;
      watchdog_fuse_config <= f;
      repeat (4) @(posedge sys_clk);
      rst <= 1'h0;
      settle();
   endtask : boot

   task cfg(input logic [7:0] c);
      wr(`WDT_KEY_ADDR, `WDT_UNLOCK_KEY);
      wr(`WDT_CTRL_ADDR, c);
      settle();
      ticks(2);
   endtask : cfg

   function int dur(input logic [3:0] c);
      dur = (c > `WDT_CODE_MAX) ? 8192 : 8 << (c - 4'h1);
   endfunction : dur

   initial
   begin
      boot(8'h25);
      rdr(`WDT_CTRL_ADDR);
      check(rd, 32'h25);
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h80, 32'h80);
      cfg(8'h03);
      rdr(`WDT_CTRL_ADDR);
      check(rd, 32'h25);
      cfg(8'h00);
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h80, 32'h80);
      debug_halt <= 1'h1;
      wr(`WDT_KEY_ADDR, `WDT_UNLOCK_KEY);
      wr(`WDT_STATUS_ADDR, 8'h00);
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h80, 32'h00);
      ticks(140);
      check_bit(sys_reset_req, 1'h0);
      boot(8'h00);
      rdr(`WDT_STATUS_ADDR);
      check(rd, 32'h0);
      rdr(8'h0c + 8'({$random(seed)} % 60) * 8'h04);
      check(rd, 32'h0);
      wr(`WDT_CTRL_ADDR, 8'h01);
      wr(`WDT_KEY_ADDR, `WDT_UNLOCK_KEY);
      repeat (4) rdr(`WDT_STATUS_ADDR);
      wr(`WDT_CTRL_ADDR, 8'h01);
      rdr(`WDT_CTRL_ADDR);
      check(rd, 32'h0);
      wr(`WDT_KEY_ADDR, `WDT_UNLOCK_KEY);
      bus(1'h1, `WDT_CTRL_ADDR, 8'h02, 4'he);
      rdr(`WDT_CTRL_ADDR);
      check(rd, 32'h0);
      for (int c = 1; c < 12; c++)
      begin
         wr(`WDT_KEY_ADDR, `WDT_UNLOCK_KEY);
         repeat (3) rdr(`WDT_STATUS_ADDR);
         wr(`WDT_CTRL_ADDR, 8'(c));
         rdr(`WDT_STATUS_ADDR);
         check(rd & 32'h1, 32'h1);
         settle();
         rdr(`WDT_CTRL_ADDR);
         check(rd, 32'(c));
      end
      repeat (3)
      begin
         code = 4'(1 + {$random(seed)} % 3);
         boot(8'h00);
         cfg({4'h0, code});
         repeat (4)
         begin
            kick();
            ticks(dur(code) / 2);
         end
         check_bit(sys_reset_req, 1'h0);
         kick();
         ticks(dur(code) + 1);
         check_bit(sys_reset_req, 1'h0);
         ticks(5);
         check_bit(sys_reset_req, 1'h1);
      end
      boot(8'h00);
      cfg(8'h01);
      cfg(8'h11);
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h300, 32'h100);
      kick();
      ticks(5);
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h300, 32'h200);
      kick();
      ticks(6);
      check_bit(sys_reset_req, 1'h1);
      boot(8'h00);
      cfg(8'h11);
      kick();
      ticks(14);
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h300, 32'h300);
      kick();
      ticks(10);
      check_bit(sys_reset_req, 1'h0);
      ticks(14);
      check_bit(sys_reset_req, 1'h1);
      boot(8'h00);
      cfg(8'h11);
      kick();
      ticks(5);
      debug_halt <= 1'h1;
      ticks(20);
      check_bit(sys_reset_req, 1'h0);
      debug_halt <= 1'h0;
      rdr(`WDT_STATUS_ADDR);
      check(rd & 32'h300, 32'h100);
      kick();
      ticks(5);
      check_bit(sys_reset_req, 1'h0);
      end_of_test();
   end
endmodule : testbench
